// >>> design/rfoc_params.svh
// Constants for the receive framing overhead capture block.
// Assumes inclusion by bare name from the design module.
`ifndef RFOC_PARAMS_SVH
`define RFOC_PARAMS_SVH
// Register offsets
`define RFOC_OFS_SYNC_DL     8'h62
`define RFOC_OFS_BOC         8'h63
`define RFOC_OFS_SEL_64      8'h64
`define RFOC_OFS_SEL_65      8'h65
`define RFOC_OFS_SEL_66      8'h66
`define RFOC_OFS_INTL_ODD    8'h67
`define RFOC_OFS_RALARM      8'h68
`define RFOC_OFS_SPARE4      8'h69
`define RFOC_OFS_SPARE5      8'h6a
`define RFOC_OFS_SPARE6      8'h6b
// Reset and fixed values
`define RFOC_RST_BYTE        8'h00
`define RFOC_FAS_PATTERN     7'h1b
`define RFOC_CNT_MAX         6'h3f
`define RFOC_LAST_FRAME      4'hf
`endif

// >>> design/rfoc_pkg.sv
// Types for the receive framing overhead capture block.
// Assumes rfoc_params.svh is on the include path.
package rfoc_pkg;
   // Per-frame E1 overhead captured at the time-slot-0 strobe
   typedef struct packed {
      logic       intl;
      logic       ralarm;
      logic [4:0] spare;  // Sa4 in bit 4 down to Sa8 in bit 0
   } rfoc_e1_ts0_t;

   // Synchroniser status levels
   typedef struct packed {
      logic crc4_mf_hunting;
      logic sig_mf_hunting;
      logic frame_align_hunting;
   } rfoc_hunt_t;

   // Multiframe assembly state
   typedef enum logic [1:0] {RFOC_IDLE, RFOC_COLLECT} rfoc_mf_state_t;

   // Whole state of the block
   typedef struct packed {
      logic [5:0]     crc4_search_count;
      logic [2:0]     hunt;
      logic [5:0]     rx_bit_code;
      logic [7:0]     rx_data_link_bits;
      logic [7:0]     loop1;
      logic [7:0]     loop2;
      logic [7:0]     loop3;
      logic [7:0]     align_frame;
      logic [7:0]     nonalign_frame;
      logic [7:0]     intl_even_acc;
      logic [7:0]     intl_odd_acc;
      logic [7:0]     ralarm_acc;
      logic [7:0]     sp4_acc;
      logic [7:0]     sp5_acc;
      logic [7:0]     sp6_acc;
      logic [7:0]     intl_even;
      logic [7:0]     intl_odd;
      logic [7:0]     ralarm;
      logic [7:0]     sp4;
      logic [7:0]     sp5;
      logic [7:0]     sp6;
      rfoc_mf_state_t mf_state;
      logic [7:0]     rd_data;
   } rfoc_state_t;
endpackage : rfoc_pkg

// >>> design/rfoc_capture.sv
// Receive framing overhead capture: CRC-4 search counter, hunt status,
// T1 bit code and data link, loop-carrier link, E1 per-frame overhead.
// Assumes framer strobes and mode bits come from logic on ref_clk_in.
//
// Functional notes
// - Count each expired 8ms CRC-4 search.
// - Clear count on CRC-4 multiframe sync.
// - Clear count while CRC-4 mode disabled.
// - Six-bit counter saturates, never wraps.
// - Read count bits 5..2 and 0.
// - Sync status bits are live, unlatched.
// - Bit 2 shows CRC-4 multiframe hunting.
// - Bit 1 shows signalling multiframe hunting.
// - Bit 0 shows basic frame hunting.
// - Bit code holds last valid code.
// - T1 data link holds FDL or Fs.
// - First received bit lands in bit 0.
// - D4 updates per multiframe, Fs in 0..5.
// - Three registers hold loop-carrier link fields.
// - Align frame: intl bit plus pattern.
// - Non-align frame: intl, one, alarm, spares.
// - Even frame intl bits, 14 high.
// - Odd frame intl bits, 15 high.
// - Odd frame remote alarm bits captured.
// - Odd frame Sa4..Sa6 bits captured.
// - Offsets 62, 64-66 decode by mode.
// - Mode select: 0 T1, 1 E1.
// - CRC-4 enable gates only the search counter.
// - Frame format: 0 ESF, 1 D4.
`timescale 1ns/1ps
`include "rfoc_params.svh"

module rfoc_capture
   (
   // Clock and reset
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_n_in,
   // Mode configuration
   input  wire logic                  rx_line_standard_sel_in,
   input  wire logic                  crc4_rx_enable_in,
   input  wire logic                  rx_frame_format_sel_in,
   // Synchroniser events and status
   input  wire logic                  crc4_search_expired_in,
   input  wire logic                  crc4_mf_synced_in,
   input  wire rfoc_pkg::rfoc_hunt_t  hunt_in,
   // T1 overhead
   input  wire logic                  bit_code_valid_in,
   input  wire logic [5:0]            bit_code_in,
   input  wire logic                  data_link_valid_in,
   input  wire logic [7:0]            data_link_in,
   input  wire logic                  fs_mf_done_in,
   input  wire logic [5:0]            fs_bits_in,
   input  wire logic                  loop_link_valid_in,
   input  wire logic [10:0]           loop_c_in,
   input  wire logic [2:0]            loop_m_in,
   input  wire logic [1:0]            loop_a_in,
   input  wire logic [3:0]            loop_s_in,
   // E1 time slot 0
   input  wire logic                  ts0_valid_in,
   input  wire logic [3:0]            frame_num_in,
   input  wire rfoc_pkg::rfoc_e1_ts0_t ts0_in,
   input  wire logic                  frame_aligned_in,
   // Register read port and ignored write inputs
   input  wire logic                  rd_en_in,
   input  wire logic [7:0]            rd_addr_in,
   input  wire logic                  wr_en_in,
   input  wire logic [7:0]            wr_data_in,
   output logic      [7:0]            rd_data_out
   );

   // ************************************************************
   // Helpers
   // ************************************************************

   // Spread a bit into its frame position within an 8-bit capture
   function automatic logic [7:0] rfoc_place(input logic [7:0] acc, input logic [2:0] idx, input logic b);
      logic [7:0] r;
      r      = acc;
      r[idx] = b;
      return r;
   endfunction : rfoc_place

   // Saturating increment of the CRC-4 search counter
   function automatic logic [5:0] rfoc_sat_inc(input logic [5:0] v);
      return (v == `RFOC_CNT_MAX) ? v : v + 6'h01;
   endfunction : rfoc_sat_inc

   // ************************************************************
   // State
   // ************************************************************

   rfoc_pkg::rfoc_state_t state_reg;
   rfoc_pkg::rfoc_state_t state_next;
   logic                  e1_mode;
   logic                  wr_ignored;
   logic [2:0]            slot;

   assign e1_mode    = rx_line_standard_sel_in;
   assign slot       = frame_num_in[3:1];
   // Writes have no target in this block; they are dropped
   assign wr_ignored = wr_en_in & (|wr_data_in);

   // Next-state logic
   always_comb
   begin
      state_next      = state_reg;
      // Live hunt status, no latching
      state_next.hunt = hunt_in;

      // CRC-4 search counter: clear has priority over a count
      if (!e1_mode || !crc4_rx_enable_in)
      begin
         state_next.crc4_search_count = 6'h00;
      end
      else if (crc4_mf_synced_in)
      begin
         state_next.crc4_search_count = 6'h00;
      end
      else if (crc4_search_expired_in)
      begin
         state_next.crc4_search_count = rfoc_sat_inc(state_reg.crc4_search_count);
      end

      // T1 overhead
      if (!e1_mode)
      begin
         if (bit_code_valid_in)
         begin
            state_next.rx_bit_code = bit_code_in;
         end
         // D4 reports Fs per multiframe, ESF reports FDL bytes
         if (rx_frame_format_sel_in && fs_mf_done_in)
         begin
            state_next.rx_data_link_bits = {2'b00, fs_bits_in};
         end
         else if (!rx_frame_format_sel_in && data_link_valid_in)
         begin
            state_next.rx_data_link_bits = data_link_in;
         end
         if (loop_link_valid_in)
         begin
            state_next.loop1 = loop_c_in[7:0];
            state_next.loop2 = {loop_m_in[1], loop_m_in[0], 3'b010, loop_c_in[10:8]};
            state_next.loop3 = {1'b1, loop_s_in, loop_a_in, loop_m_in[2]};
         end
      end

      // E1 per-frame overhead
      case (state_reg.mf_state)
         rfoc_pkg::RFOC_IDLE:
         begin
            if (e1_mode && frame_aligned_in && ts0_valid_in && frame_num_in == `RFOC_LAST_FRAME)
            begin
               state_next.mf_state = rfoc_pkg::RFOC_COLLECT;
            end
         end
         rfoc_pkg::RFOC_COLLECT:
         begin
            if (!e1_mode || !frame_aligned_in)
            begin
               state_next.mf_state = rfoc_pkg::RFOC_IDLE;
            end
            else if (ts0_valid_in)
            begin
               if (!frame_num_in[0])
               begin
                  state_next.intl_even_acc = rfoc_place(state_reg.intl_even_acc, slot, ts0_in.intl);
                  state_next.align_frame   = {ts0_in.intl, `RFOC_FAS_PATTERN};
               end
               else
               begin
                  state_next.intl_odd_acc = rfoc_place(state_reg.intl_odd_acc, slot, ts0_in.intl);
                  state_next.ralarm_acc   = rfoc_place(state_reg.ralarm_acc, slot, ts0_in.ralarm);
                  state_next.sp4_acc      = rfoc_place(state_reg.sp4_acc, slot, ts0_in.spare[4]);
                  state_next.sp5_acc      = rfoc_place(state_reg.sp5_acc, slot, ts0_in.spare[3]);
                  state_next.sp6_acc      = rfoc_place(state_reg.sp6_acc, slot, ts0_in.spare[2]);
                  state_next.nonalign_frame = {ts0_in.intl, 1'b1, ts0_in.ralarm, ts0_in.spare};
               end
               // Publish a whole multiframe at once, never a mix of two
               if (frame_num_in == `RFOC_LAST_FRAME)
               begin
                  state_next.intl_even = state_next.intl_even_acc;
                  state_next.intl_odd  = state_next.intl_odd_acc;
                  state_next.ralarm    = state_next.ralarm_acc;
                  state_next.sp4       = state_next.sp4_acc;
                  state_next.sp5       = state_next.sp5_acc;
                  state_next.sp6       = state_next.sp6_acc;
               end
            end
         end
         default:
         begin
            state_next.mf_state = rfoc_pkg::RFOC_IDLE;
         end
      endcase

      // Read mux, registered; reads change no state
      state_next.rd_data = `RFOC_RST_BYTE;
      if (rd_en_in)
      begin
         case (rd_addr_in)
            `RFOC_OFS_SYNC_DL:
               state_next.rd_data = e1_mode ? {state_reg.crc4_search_count[5:2], state_reg.crc4_search_count[0],
                                               hunt_in} : state_reg.rx_data_link_bits;
            `RFOC_OFS_BOC:       state_next.rd_data = {2'b00, state_reg.rx_bit_code};
            `RFOC_OFS_SEL_64:    state_next.rd_data = e1_mode ? state_reg.align_frame : state_reg.loop1;
            `RFOC_OFS_SEL_65:    state_next.rd_data = e1_mode ? state_reg.nonalign_frame : state_reg.loop2;
            `RFOC_OFS_SEL_66:    state_next.rd_data = e1_mode ? state_reg.intl_even : state_reg.loop3;
            `RFOC_OFS_INTL_ODD:  state_next.rd_data = state_reg.intl_odd;
            `RFOC_OFS_RALARM:    state_next.rd_data = state_reg.ralarm;
            `RFOC_OFS_SPARE4:    state_next.rd_data = state_reg.sp4;
            `RFOC_OFS_SPARE5:    state_next.rd_data = state_reg.sp5;
            `RFOC_OFS_SPARE6:    state_next.rd_data = state_reg.sp6;
            default:             state_next.rd_data = `RFOC_RST_BYTE;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_reg          <= '0;
         state_reg.mf_state <= rfoc_pkg::RFOC_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign rd_data_out = state_reg.rd_data;

   // ************************************************************
   // Checks
   // ************************************************************

   AST_CNT_CLR_DIS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      !crc4_rx_enable_in |=> state_reg.crc4_search_count == 6'h00)
      else $error("search count not cleared with CRC-4 off");

   AST_CNT_CLR_SYNC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      crc4_mf_synced_in |=> state_reg.crc4_search_count == 6'h00)
      else $error("search count not cleared on sync");

   AST_CNT_INC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (e1_mode && crc4_rx_enable_in && !crc4_mf_synced_in && crc4_search_expired_in &&
       state_reg.crc4_search_count != `RFOC_CNT_MAX)
      |=> state_reg.crc4_search_count == $past(state_reg.crc4_search_count) + 6'h01)
      else $error("search count did not step");

   AST_CNT_SAT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (state_reg.crc4_search_count == `RFOC_CNT_MAX && e1_mode && crc4_rx_enable_in && !crc4_mf_synced_in)
      |=> state_reg.crc4_search_count == `RFOC_CNT_MAX)
      else $error("search count wrapped");

   AST_SYNC_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (rd_en_in && rd_addr_in == `RFOC_OFS_SYNC_DL && e1_mode)
      |=> rd_data_out[7:3] == {$past(state_reg.crc4_search_count[5:2]), $past(state_reg.crc4_search_count[0])})
      else $error("search count read layout wrong");

   AST_HUNT_LIVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (rd_en_in && rd_addr_in == `RFOC_OFS_SYNC_DL && e1_mode) |=> rd_data_out[2:0] == $past(hunt_in))
      else $error("hunt status not live");

   // A dropped write must never turn into read data
   AST_WR_IGNORED: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (wr_ignored && !rd_en_in) |=> rd_data_out == `RFOC_RST_BYTE)
      else $error("write changed read data");

   AST_BOC_TOP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (rd_en_in && rd_addr_in == `RFOC_OFS_BOC) |=> rd_data_out[7:6] == 2'b00)
      else $error("bit code upper bits not zero");

   AST_D4_FS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!e1_mode && rx_frame_format_sel_in && fs_mf_done_in)
      |=> state_reg.rx_data_link_bits == {2'b00, $past(fs_bits_in)})
      else $error("Fs bits not captured");

   AST_MF_PUBLISH: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (state_reg.mf_state == rfoc_pkg::RFOC_COLLECT && e1_mode && frame_aligned_in && ts0_valid_in &&
       frame_num_in == `RFOC_LAST_FRAME)
      |=> state_reg.intl_odd[7] == $past(ts0_in.intl) && state_reg.ralarm[7] == $past(ts0_in.ralarm))
      else $error("multiframe capture not published");

endmodule : rfoc_capture

// >>> test/rfoc_line_model.sv
// Line-side model: remote terminal sending E1 time-slot-0 overhead.
// Assumes the bench calls send_mf and that capture happens on rising edges.
`timescale 1ns/1ps

module rfoc_line_model
   (
   // Clock
   input  wire logic              ref_clk_in,
   // E1 time slot 0 toward the capture block
   output logic                   ts0_valid_out,
   output logic [3:0]             frame_num_out,
   output rfoc_pkg::rfoc_e1_ts0_t ts0_out,
   output logic                   frame_aligned_out
   );
   // *******************************************************************
   // Idle levels and multiframe sender
   // *******************************************************************
   initial
   begin
      ts0_valid_out     = 1'b0;
      frame_num_out     = 4'h0;
      ts0_out           = '0;
      frame_aligned_out = 1'b0;
   end

   // One frame 15 to gain lock, then frames 0..15 in order; even frames carry
   // inverted alarm and spare bits so a capture of the wrong parity shows up
   task automatic send_mf(input logic [7:0] ie, io, ra, s4, s5, s6);
      int         f;
      logic [2:0] k;
      for (int i = 0; i < 17; i++)
      begin
         f = (i == 0) ? 15 : i - 1;
         k = 3'(f / 2);
         @(negedge ref_clk_in);
         frame_aligned_out = 1'b1;
         ts0_valid_out     = 1'b1;
         frame_num_out     = 4'(f);
         ts0_out.intl      = f[0] ? io[k] : ie[k];
         ts0_out.ralarm    = ra[k] ^ ~f[0];
         ts0_out.spare     = {s4[k], s5[k], s6[k], 2'b10} ^ {5{~f[0]}};
         @(negedge ref_clk_in);
         ts0_valid_out     = 1'b0;
         ts0_out           = ~ts0_out; // Not held past the strobe
         repeat (2) @(negedge ref_clk_in);
      end
   endtask : send_mf
endmodule : rfoc_line_model

// >>> test/rfoc_capture_tb.sv
// Self-checking bench for the receive framing overhead capture block.
// Assumes read data is registered and stands one cycle after the request edge.
`timescale 1ns/1ps

module rfoc_capture_tb;
   // *******************************************************************
   // Signals, clock and instances
   // *******************************************************************
   localparam logic [7:0] IE = 8'h96, IO = 8'h3c, RA = 8'hc5, S4 = 8'h5a, S5 = 8'ha3, S6 = 8'h0f;
   logic                   ref_clk, rst_n, std_sel, crc4_en, fmt_sel, ts0_v, aligned;
   logic                   rd_en, wr_en;
   logic [5:0]             ev, code, fs;
   logic [7:0]             dl, rd_addr, wr_data, rd_data;
   logic [10:0]            lc;
   logic [2:0]             lm;
   logic [1:0]             la;
   logic [3:0]             ls, fnum;
   rfoc_pkg::rfoc_hunt_t   hunt;
   rfoc_pkg::rfoc_e1_ts0_t ts0;
   int                     errors, check_count;

   // Free-running 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   rfoc_line_model u_line (.ref_clk_in(ref_clk), .ts0_valid_out(ts0_v), .frame_num_out(fnum),
                           .ts0_out(ts0), .frame_aligned_out(aligned));

   rfoc_capture u_dut (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .rx_line_standard_sel_in(std_sel),
      .crc4_rx_enable_in(crc4_en), .rx_frame_format_sel_in(fmt_sel), .crc4_search_expired_in(ev[0]),
      .crc4_mf_synced_in(ev[1]), .hunt_in(hunt), .bit_code_valid_in(ev[2]), .bit_code_in(code),
      .data_link_valid_in(ev[3]), .data_link_in(dl), .fs_mf_done_in(ev[4]), .fs_bits_in(fs),
      .loop_link_valid_in(ev[5]), .loop_c_in(lc), .loop_m_in(lm), .loop_a_in(la), .loop_s_in(ls),
      .ts0_valid_in(ts0_v), .frame_num_in(fnum), .ts0_in(ts0), .frame_aligned_in(aligned),
      .rd_en_in(rd_en), .rd_addr_in(rd_addr), .wr_en_in(wr_en), .wr_data_in(wr_data),
      .rd_data_out(rd_data));

   // *******************************************************************
   // Access tasks
   // *******************************************************************
   // One-cycle event strobe; a low cycle always follows
   task automatic pulse(input logic [5:0] m);
      @(negedge ref_clk);
      ev = m;
      @(negedge ref_clk);
      ev = 6'h00;
   endtask : pulse

   // Read, then compare the answer in the cycle it stands
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      rd_en   = 1'b1;
      rd_addr = a;
      @(negedge ref_clk);
      rd_en   = 1'b0;
      check_count++;
      if (rd_data !== exp)
      begin
         errors++;
         $display("unexpected rd_data_out at %h: expected %h seen %h", a, exp, rd_data);
      end
   endtask : rd

   // Write attempt, which must leave every register untouched
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      wr_en   = 1'b1;
      rd_addr = a;
      wr_data = d;
      @(negedge ref_clk);
      wr_en   = 1'b0;
   endtask : wr

   task automatic test_done;
      if (errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   // Hang guard, far beyond the few hundred cycles the sequence needs
   initial
   begin
      #100000;
      errors++;
      test_done();
   end

   // *******************************************************************
   // Test sequence
   // *******************************************************************
   initial
   begin
      errors = 0;
      check_count = 0;
      rst_n = 1'b0;
      std_sel = 1'b1;
      crc4_en = 1'b1;
      fmt_sel = 1'b0;
      ev = 6'h00;
      hunt = 3'b000;
      {code, fs, dl, lc, lm, la, ls} = '0;
      {rd_en, wr_en, rd_addr, wr_data} = '0;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      // Reset values at every offset in E1 mode plus one unmapped place
      for (int a = 8'h62; a <= 8'h6c; a++)
         rd((a == 8'h6c) ? 8'h70 : 8'(a), 8'h00);
      // Search counter, hidden bit 1 and live hunt flags
      hunt = 3'b101;
      repeat (5) pulse(6'h01);
      rd(8'h62, 8'h1d);
      hunt = 3'b010;
      rd(8'h62, 8'h1a);
      repeat (70) pulse(6'h01);
      rd(8'h62, 8'hfa);
      hunt = 3'b000;
      pulse(6'h02);
      repeat (3) pulse(6'h01);
      wr(8'h62, 8'hff);
      rd(8'h62, 8'h08);
      crc4_en = 1'b0;
      rd(8'h62, 8'h00);
      crc4_en = 1'b1;
      // E1 overhead of one whole aligned multiframe
      u_line.send_mf(IE, IO, RA, S4, S5, S6);
      rd(8'h64, {IE[7], 7'h1b});
      rd(8'h65, {IO[7], 1'b1, RA[7], S4[7], S5[7], S6[7], 2'b10});
      wr(8'h66, 8'h00);
      rd(8'h66, IE);
      rd(8'h67, IO);
      rd(8'h68, RA);
      rd(8'h69, S4);
      rd(8'h6a, S5);
      rd(8'h6b, S6);
      // T1 bit code, data link in both formats, loop-carrier link
      std_sel = 1'b0;
      code = 6'h2b;
      pulse(6'h04);
      code = 6'h15;
      rd(8'h63, 8'h2b);
      dl = 8'hb4;
      pulse(6'h08);
      rd(8'h62, 8'hb4);
      fmt_sel = 1'b1;
      fs = 6'h2d;
      pulse(6'h10);
      rd(8'h62, 8'h2d);
      {lc, lm, la, ls} = {11'h5a3, 3'b101, 2'b10, 4'b0110};
      pulse(6'h20);
      rd(8'h64, lc[7:0]);
      rd(8'h65, {lm[1], lm[0], 3'b010, lc[10:8]});
      rd(8'h66, {1'b1, ls, la, lm[2]});
      test_done();
   end
endmodule : rfoc_capture_tb
